/* File: design/sgc_pkg.sv */
// package: register map, reset values and timing constants of the global control bank
package sgc_pkg;
    localparam logic [7:0] SGC_OFF_STORM_HIGH = 8'h06;
    localparam logic [7:0] SGC_OFF_STORM_LOW = 8'h07;
    localparam logic [7:0] SGC_OFF_TEST_A = 8'h08;
    localparam logic [7:0] SGC_OFF_TEST_B = 8'h09;
    localparam logic [7:0] SGC_OFF_TEST_C = 8'h0a;
    localparam logic [7:0] SGC_OFF_CLK_SEL = 8'h0b;
    localparam logic [7:0] SGC_OFF_PRIO_MAP = 8'h0c;

    localparam logic [2:0] SGC_RST_STORM_HIGH = 3'h0;
    localparam logic [7:0] SGC_RST_STORM_LOW = 8'h63;
    localparam logic [7:0] SGC_RST_TEST_A = 8'h00;
    localparam logic [7:0] SGC_RST_TEST_B = 8'h24;
    localparam logic [7:0] SGC_RST_TEST_C = 8'h35;
    localparam logic [1:0] SGC_RST_CLK_SEL = 2'h2;
    localparam logic [5:0] SGC_RST_CLK_RSVD = 6'h08;
    localparam logic [7:0] SGC_RST_PRIO_MAP = 8'h50;

    localparam int SGC_STORM_HIGH_MSB = 2;
    localparam int SGC_CLK_SEL_LSB = 6;
    localparam int SGC_PCP3_LSB = 6;
    localparam int SGC_PCP2_LSB = 4;
    localparam int SGC_PCP1_LSB = 2;
    localparam int SGC_PCP0_LSB = 0;

    localparam logic [1:0] SGC_CLK_31M25 = 2'h0;
    localparam logic [1:0] SGC_CLK_62M5 = 2'h1;
    localparam logic [1:0] SGC_CLK_125M = 2'h2;

    localparam int SGC_BLOCK_BYTES = 64;
    localparam longint SGC_CLK_PERIOD_PS = 5000;
    localparam longint SGC_PERIOD_100M_MS = 67;
    localparam longint SGC_PERIOD_10M_MS = 500;
    localparam longint SGC_CYC_100M = SGC_PERIOD_100M_MS * 1000000000 / SGC_CLK_PERIOD_PS;
    localparam longint SGC_CYC_10M = SGC_PERIOD_10M_MS * 1000000000 / SGC_CLK_PERIOD_PS;
endpackage

/* File: design/sgc_port_meter.sv */
// per-port broadcast block counter with period timer
`timescale 1ns/100ps
`default_nettype none
module sgc_port_meter
    import sgc_pkg::*;
#(
    parameter int TIMER_W = 27,
    parameter longint CYC_100M = SGC_CYC_100M,
    parameter longint CYC_10M = SGC_CYC_10M
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic speed_10m,
    input wire logic [10:0] threshold,
    input wire logic bcast_block,
    output logic over_limit
);
    // elaboration check: both periods must fit the timer, or the truncated end count cuts the period short
    if (TIMER_W < 1 || TIMER_W > 63 || CYC_100M < 1 || CYC_10M < 1 ||
            CYC_100M >= (64'h1 << TIMER_W) || CYC_10M >= (64'h1 << TIMER_W)) begin : g_bad_timer
        $error("sgc_port_meter: timer width too small");
    end

    logic [TIMER_W-1:0] timer_reg, timer_next;
    logic [10:0] count_reg, count_next;
    logic [TIMER_W-1:0] last_cyc;

    // period length follows current link speed
    always_comb begin
        last_cyc = speed_10m ? TIMER_W'(CYC_10M - 1) : TIMER_W'(CYC_100M - 1);
        timer_next = timer_reg + 1'b1;
        count_next = count_reg;
        if (timer_reg >= last_cyc) begin
            timer_next = '0;
            count_next = '0;
        end else if (bcast_block && count_reg < threshold) begin
            count_next = count_reg + 11'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            timer_reg <= '0;
            count_reg <= '0;
        end else begin
            timer_reg <= timer_next;
            count_reg <= count_next;
        end
    end

    // a block is dropped once the allowance is used up
    assign over_limit = (count_reg >= threshold);
endmodule
`default_nettype wire

/* File: design/sgc_regs.sv */
// global control registers: storm threshold, test regs, clock select, priority map
//
// Notes on behaviour
// - the 11-bit storm threshold joins bits 2-0 of the high register above bits 7-0 of the low one.
// - the threshold counts 64-byte blocks of packet data allowed per input port per period.
// - the period is 67 ms at 100 Mbps and 500 ms at 10 Mbps.
// - the threshold resets to 0x63 with its upper three bits at 000.
// - three read-only test registers read 0x00, 0x24 and 0x35 and software leaves them alone.
// - the cpu clock selector picks 31.25, 62.5 or 125 MHz for codes 00, 01, 10 and resets to 10.
// - tag values 3, 2, 1 map through two-bit fields that reset to 01, 01, 00.
// - tag value 0 maps through bits 1-0, which reset to 00.
`timescale 1ns/100ps
`default_nettype none
module sgc_regs
    import sgc_pkg::*;
#(
    parameter int NUM_PORTS = 3,
    parameter int TIMER_W = 27,
    parameter longint CYC_100M = SGC_CYC_100M,
    parameter longint CYC_10M = SGC_CYC_10M
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [NUM_PORTS-1:0] port_speed_10m,
    input wire logic [NUM_PORTS-1:0] bcast_block,
    output logic [NUM_PORTS-1:0] bcast_drop,
    input wire logic [2:0] frame_pcp,
    output logic [1:0] frame_priority,
    output logic [1:0] cpu_clk_sel,
    output logic [10:0] storm_threshold
);
    if (NUM_PORTS < 1) begin : g_bad_ports
        $error("sgc_regs: NUM_PORTS must be at least 1");
    end

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [2:0] storm_high_reg, storm_high_next;
    logic [7:0] storm_low_reg, storm_low_next;
    logic [1:0] clk_sel_reg, clk_sel_next;
    logic [7:0] prio_map_reg, prio_map_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [1:0] prio_reg, prio_next;
    logic [NUM_PORTS-1:0] drop_reg, drop_next;
    logic [NUM_PORTS-1:0] over_limit;
    logic [10:0] threshold;

    function automatic logic [1:0] map_field(input logic [7:0] map, input int lsb);
        map_field = map[lsb +: 2];
    endfunction

    assign threshold = {storm_high_reg, storm_low_reg};

    // writes; test regs and reserved select bits have no storage so writes vanish
    always_comb begin
        storm_high_next = storm_high_reg;
        storm_low_next = storm_low_reg;
        clk_sel_next = clk_sel_reg;
        prio_map_next = prio_map_reg;
        if (reg_wr) begin
            case (reg_addr)
                SGC_OFF_STORM_HIGH: storm_high_next = reg_wdata[SGC_STORM_HIGH_MSB:0];
                SGC_OFF_STORM_LOW: storm_low_next = reg_wdata;
                SGC_OFF_CLK_SEL: clk_sel_next = reg_wdata[SGC_CLK_SEL_LSB +: 2];
                SGC_OFF_PRIO_MAP: prio_map_next = reg_wdata;
                default: storm_high_next = storm_high_reg;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read path, one cycle after the strobe; unmapped offsets read zero
    // ----------------------------------------------------------------
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            case (reg_addr)
                SGC_OFF_STORM_HIGH: rdata_next = {5'h00, storm_high_reg};
                SGC_OFF_STORM_LOW: rdata_next = storm_low_reg;
                SGC_OFF_TEST_A: rdata_next = SGC_RST_TEST_A;
                SGC_OFF_TEST_B: rdata_next = SGC_RST_TEST_B;
                SGC_OFF_TEST_C: rdata_next = SGC_RST_TEST_C;
                SGC_OFF_CLK_SEL: rdata_next = {clk_sel_reg, SGC_RST_CLK_RSVD};
                SGC_OFF_PRIO_MAP: rdata_next = prio_map_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // priority lookup for the low tag values
    // ----------------------------------------------------------------
    always_comb begin
        case (frame_pcp)
            3'h3: prio_next = map_field(prio_map_reg, SGC_PCP3_LSB);
            3'h2: prio_next = map_field(prio_map_reg, SGC_PCP2_LSB);
            3'h1: prio_next = map_field(prio_map_reg, SGC_PCP1_LSB);
            3'h0: prio_next = map_field(prio_map_reg, SGC_PCP0_LSB);
            // higher tags belong to the next register, not held here
            default: prio_next = 2'h0;
        endcase
        drop_next = bcast_block & over_limit;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            storm_high_reg <= SGC_RST_STORM_HIGH;
            storm_low_reg <= SGC_RST_STORM_LOW;
            clk_sel_reg <= SGC_RST_CLK_SEL;
            prio_map_reg <= SGC_RST_PRIO_MAP;
            rdata_reg <= 8'h00;
            prio_reg <= 2'h0;
            drop_reg <= '0;
        end else begin
            storm_high_reg <= storm_high_next;
            storm_low_reg <= storm_low_next;
            clk_sel_reg <= clk_sel_next;
            prio_map_reg <= prio_map_next;
            rdata_reg <= rdata_next;
            prio_reg <= prio_next;
            drop_reg <= drop_next;
        end
    end

    // ----------------------------------------------------------------
    // per-port meters
    // ----------------------------------------------------------------
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_meter
        sgc_port_meter #(
            .TIMER_W(TIMER_W),
            .CYC_100M(CYC_100M),
            .CYC_10M(CYC_10M)
        ) u_meter (
            .clk(clk),
            .reset(reset),
            .speed_10m(port_speed_10m[p]),
            .threshold(threshold),
            .bcast_block(bcast_block[p]),
            .over_limit(over_limit[p])
        );
    end

    assign reg_rdata = rdata_reg;
    assign frame_priority = prio_reg;
    assign bcast_drop = drop_reg;
    assign cpu_clk_sel = clk_sel_reg;
    assign storm_threshold = threshold;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_storm_low_write: assert property (@(posedge clk) disable iff (reset)
        reg_wr && reg_addr == SGC_OFF_STORM_LOW |=> storm_threshold[7:0] == $past(reg_wdata))
        else $error("low threshold byte not written");
    a_storm_high_write: assert property (@(posedge clk) disable iff (reset)
        reg_wr && reg_addr == SGC_OFF_STORM_HIGH |=>
        storm_threshold[10:8] == $past(reg_wdata[2:0]))
        else $error("high threshold bits not written");
    a_reset_values: assert property (@(posedge clk)
        reset |=> storm_threshold == 11'h063 && cpu_clk_sel == 2'h2)
        else $error("wrong reset value");
    a_test_reg_read: assert property (@(posedge clk) disable iff (reset)
        reg_rd && reg_addr == SGC_OFF_TEST_B |=> reg_rdata == 8'h24)
        else $error("test register b misread");
    a_clk_rsvd_read: assert property (@(posedge clk) disable iff (reset)
        reg_rd && reg_addr == SGC_OFF_CLK_SEL |=> reg_rdata[5:0] == 6'h08 &&
        reg_rdata[7:6] == $past(cpu_clk_sel))
        else $error("clock select reserved bits misread");
    a_clk_sel_write: assert property (@(posedge clk) disable iff (reset)
        reg_wr && reg_addr == SGC_OFF_CLK_SEL |=> cpu_clk_sel == $past(reg_wdata[7:6]))
        else $error("clock select not written");
    a_pcp_three_map: assert property (@(posedge clk) disable iff (reset)
        frame_pcp == 3'h3 && !reg_wr |=> frame_priority == prio_map_reg[7:6])
        else $error("tag three mapping wrong");
    a_pcp_zero_map: assert property (@(posedge clk) disable iff (reset)
        frame_pcp == 3'h0 && !reg_wr |=> frame_priority == prio_map_reg[1:0])
        else $error("tag zero mapping wrong");
    a_drop_on_limit: assert property (@(posedge clk) disable iff (reset)
        bcast_block[0] && over_limit[0] |=> bcast_drop[0])
        else $error("block over limit not dropped");
endmodule
`default_nettype wire

/* File: sim/sgc_host_model.sv */
// host processor model driving the management register strobes
`timescale 1ns/100ps
`default_nettype none
module sgc_host_model (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // on its own the host never writes the test registers; only bench-ordered writes do
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~data;
    endtask
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~addr;
        @(negedge clk);
        data = reg_rdata;
    endtask
    // slowest adequate clock, which keeps interface power down
    function automatic logic [1:0] pick_clock(input int serial_khz);
        if (serial_khz < 6000) return 2'h0;
        if (serial_khz <= 12500) return 2'h1;
        return 2'h2;
    endfunction
endmodule
`default_nettype wire

/* File: sim/switch_global_control_regs_bench.sv */
// self-checking bench for the global control register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); end end
module switch_global_control_regs_bench
    import sgc_pkg::*;
;
    typedef struct {logic [7:0] addr; logic [7:0] value;} sgc_row_t;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] bcast_block = 3'h0;
    logic [2:0] frame_pcp = 3'h0;
    wire [7:0] reg_addr;
    wire [7:0] reg_wdata;
    wire reg_wr;
    wire reg_rd;
    logic [7:0] reg_rdata;
    logic [2:0] bcast_drop;
    logic [1:0] frame_priority;
    logic [1:0] cpu_clk_sel;
    logic [10:0] storm_threshold;
    logic [7:0] rd_data;
    int failures = 0;
    int checks_done = 0;
    int speeds [3] = '{4000, 10000, 20000};
    logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h2};
    sgc_row_t rows [8] = '{'{8'h06, 8'h00}, '{8'h07, 8'h63}, '{8'h08, 8'h00}, '{8'h09, 8'h24},
        '{8'h0a, 8'h35}, '{8'h0b, 8'h88}, '{8'h0c, 8'h50}, '{8'h20, 8'h00}};

    // short periods keep the run brief: 50 cycles at 100 Mbps, 200 at 10 Mbps
    sgc_regs #(.NUM_PORTS(3), .TIMER_W(27), .CYC_100M(50), .CYC_10M(200)) u_dut (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .port_speed_10m(3'h6), .bcast_block(bcast_block), .bcast_drop(bcast_drop),
        .frame_pcp(frame_pcp), .frame_priority(frame_priority),
        .cpu_clk_sel(cpu_clk_sel), .storm_threshold(storm_threshold));
    sgc_host_model u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic close_out();
        $display("checks_done %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(negedge clk);
        reset = 1'b1;
        repeat (5) @(negedge clk);
        reset = 1'b0;
    endtask
    // the drop for the last block shows in the cycle just after it
    task automatic send_blocks(input logic [2:0] mask, input int n);
        @(negedge clk);
        bcast_block = mask;
        repeat (n) @(negedge clk);
        bcast_block = 3'h0;
    endtask

    initial begin
        #20000;
        failures++;
        close_out();
    end

    initial begin
        do_reset();
        `CHK("threshold", 11'h063, storm_threshold)
        `CHK("clock select", 2'h2, cpu_clk_sel)
        for (int i = 0; i < 8; i++) begin
            u_host.read_reg(rows[i].addr, rd_data);
            `CHK("reset read", rows[i].value, rd_data)
        end
        for (int i = 0; i < 3; i++) begin
            u_host.write_reg(SGC_OFF_CLK_SEL, {u_host.pick_clock(speeds[i]), 6'h3f});
            u_host.read_reg(SGC_OFF_CLK_SEL, rd_data);
            `CHK("clock select", codes[i], cpu_clk_sel)
            `CHK("clock readback", ({codes[i], 6'h08}), rd_data)
        end
        for (int a = 8; a <= 10; a++) begin
            u_host.write_reg(8'(a), 8'hff);
            u_host.read_reg(8'(a), rd_data);
            `CHK("test register", rows[a-6].value, rd_data)
        end
        u_host.write_reg(SGC_OFF_STORM_HIGH, 8'hfd);
        u_host.write_reg(SGC_OFF_STORM_LOW, 8'h5a);
        u_host.read_reg(SGC_OFF_STORM_HIGH, rd_data);
        `CHK("threshold", 11'h55a, storm_threshold)
        `CHK("high readback", 8'h05, rd_data)
        u_host.write_reg(SGC_OFF_PRIO_MAP, 8'h1b);
        for (int p = 0; p < 5; p++) begin
            @(negedge clk);
            frame_pcp = 3'(p);
            repeat (2) @(negedge clk);
            `CHK("priority", (p < 4) ? 2'(p ^ 3) : 2'h0, frame_priority)
        end
        do_reset();
        `CHK("threshold again", 11'h063, storm_threshold)
        u_host.write_reg(SGC_OFF_STORM_LOW, 8'h02);
        send_blocks(3'h3, 2);
        `CHK("drop in limit", 3'h0, bcast_drop)
        send_blocks(3'h3, 1);
        `CHK("drop over limit", 3'h3, bcast_drop)
        repeat (50) @(negedge clk);
        send_blocks(3'h3, 1);
        `CHK("drop next period", 3'h2, bcast_drop)
        close_out();
    end
endmodule
`default_nettype wire
